// ==== src/wake_ctrl_pkg.sv ====
// Shared constants and carrier types for the reset, wake and strap control block
package wake_ctrl_pkg;

    // ----------------------------------------------------------------
    // Clocking
    // ----------------------------------------------------------------
    localparam int unsigned REF_CLK_HZ = 25000000;
    localparam int unsigned CLK_HZ = 10000000;

    // ----------------------------------------------------------------
    // Register bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] BYTE_ORDER_TEST_OFS = 8'h00;
    localparam logic [7:0] WAKE_CONFIG_OFS = 8'h04;
    localparam logic [7:0] POWER_CONTROL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;

    // Readback pattern of the byte order test register, value is arbitrary
    localparam logic [31:0] BYTE_ORDER_TEST_VALUE = 32'h0A0B0C0D;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned CFG_WAKE_EN_BIT = 0;
    localparam int unsigned CFG_POL_HIGH_BIT = 1;
    localparam int unsigned CFG_PUSH_PULL_BIT = 2;
    localparam int unsigned PWR_SLEEP_BIT = 0;
    localparam int unsigned ST_ASLEEP_BIT = 0;
    localparam int unsigned ST_WRITES_OK_BIT = 1;
    localparam int unsigned ST_STRAP_BIT = 2;
    localparam int unsigned ST_WAKE_PEND_BIT = 3;
    localparam int unsigned ST_SPEED100_BIT = 4;
    localparam int unsigned ST_FULL_DUPLEX_BIT = 5;
    localparam int unsigned ST_AUTONEG_BIT = 6;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic RST_WAKE_EN = 1'b0;
    localparam logic RST_POL_HIGH = 1'b0;
    localparam logic RST_PUSH_PULL = 1'b0;
    localparam logic [31:0] RST_RDATA = 32'h00000000;

    // Release of the core reset trails the reset inputs by this many edges
    localparam int unsigned RESET_SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP
    } power_state_t;

    typedef struct packed {
        logic wake_enable;
        logic polarity_high;
        logic push_pull;
    } wake_config_t;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic autoneg;
    } eth_defaults_t;

endpackage

// ==== src/reset_release_sync.sv ====
// Combines internal power-on reset and hard reset pin, releases on the clock
`timescale 1ns/1ps

module reset_release_sync
(
    // Clock and internal power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // Hard reset pin, active low, weakly pulled high outside
    input wire logic hard_reset_pin,
    // Synchronised core reset, active low
    output logic core_rst_n
);

    logic [wake_ctrl_pkg::RESET_SYNC_STAGES-1:0] stage;
    logic [wake_ctrl_pkg::RESET_SYNC_STAGES-1:0] next_stage;

    // ----------------------------------------------------------------
    // Release shift chain
    // ----------------------------------------------------------------
    always_comb
    begin
        if (!rst_n || !hard_reset_pin)
        begin
            next_stage = '0;
        end
        else
        begin
            next_stage = {stage[wake_ctrl_pkg::RESET_SYNC_STAGES-2:0], 1'b1};
        end
    end

    always_ff @(posedge clk)
    begin
        stage <= next_stage;
    end

    assign core_rst_n = stage[wake_ctrl_pkg::RESET_SYNC_STAGES-1];

endmodule // reset_release_sync

// ==== src/reset_wake_strap_control.sv ====
// Reset, power-saving wake, wake indicator and speed strap control
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// - Hard reset pin low resets everything
// - Floating reset pin leaves power-on reset alone
// - Writes ignored until a read after reset/wake
// - Enabled wake indicator asserts on wake event
// - Indicator polarity and drive type are configurable
// - Wake events never end the sleep state
// - Only a host write cycle or a core reset ends sleep
// - Any written data value wakes the device
// - Speed strap latched at reset release
// - Runs from the single reference clock
// - Strap 0: 10M half no-AN; 1: 100M half AN
module reset_wake_strap_control
(
    // Clock and internal power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // Hard reset pin, active low
    input wire logic hard_reset_pin,
    // Host strobe pins used to detect a wake write
    input wire logic chip_select_low,
    input wire logic write_strobe_low,
    // Register port
    input wire logic [wake_ctrl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wake_ctrl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [wake_ctrl_pkg::DATA_W-1:0] reg_rdata,
    // Power management event and speed strap
    input wire logic wake_event,
    input wire logic speed_strap,
    // Wake indicator pin
    output logic wake_indicator_out,
    output logic wake_indicator_oe,
    // Power state and latched Ethernet defaults
    output logic asleep,
    output logic writes_enabled,
    output wake_ctrl_pkg::eth_defaults_t eth_defaults
);

    // ----------------------------------------------------------------
    // Core reset
    // ----------------------------------------------------------------
    logic core_rst_n;

    reset_release_sync u_reset_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .hard_reset_pin(hard_reset_pin),
        .core_rst_n(core_rst_n)
    );

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
        addr_is = (addr == ofs);
    endfunction

    function automatic logic is_asleep(input wake_ctrl_pkg::power_state_t state);
        is_asleep = (state == wake_ctrl_pkg::PWR_SLEEP);
    endfunction

    function automatic wake_ctrl_pkg::eth_defaults_t strap_defaults(input logic strap);
        wake_ctrl_pkg::eth_defaults_t d;
        d.speed_100 = strap;
        d.full_duplex = 1'b0;
        d.autoneg = strap;
        strap_defaults = d;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    wake_ctrl_pkg::power_state_t power_state;
    wake_ctrl_pkg::power_state_t next_power_state;
    wake_ctrl_pkg::wake_config_t wake_config;
    wake_ctrl_pkg::wake_config_t next_wake_config;
    logic read_seen;
    logic next_read_seen;
    logic wake_pending;
    logic next_wake_pending;
    logic strap_taken;
    logic next_strap_taken;
    logic strap_value;
    logic next_strap_value;
    wake_ctrl_pkg::eth_defaults_t next_eth_defaults;
    logic [wake_ctrl_pkg::DATA_W-1:0] next_reg_rdata;
    logic next_wake_indicator_out;
    logic next_wake_indicator_oe;
    logic next_asleep;
    logic next_writes_enabled;

    logic host_write_pins;
    logic write_ok;
    logic wr_config;
    logic wr_power;
    logic wr_status;
    logic indicator_active;
    logic indicator_level;
    logic wake_write;
    logic clear_pending;
    logic [wake_ctrl_pkg::DATA_W-1:0] status_word;

    // Pin-level write cycle, qualified only by chip select and write strobe
    assign host_write_pins = !chip_select_low && !write_strobe_low;

    // Register writes need an earlier read and a running device
    assign write_ok = reg_write && read_seen && (power_state == wake_ctrl_pkg::PWR_RUN);

    assign wr_config = write_ok && addr_is(reg_addr, wake_ctrl_pkg::WAKE_CONFIG_OFS);
    assign wr_power = write_ok && addr_is(reg_addr, wake_ctrl_pkg::POWER_CONTROL_OFS);
    assign wr_status = write_ok && addr_is(reg_addr, wake_ctrl_pkg::STATUS_OFS);

    // Sleep ends on the pin cycle alone, so a host with any address still wakes us
    assign wake_write = is_asleep(power_state) && host_write_pins;

    // Writing one to the pending bit clears it
    assign clear_pending = wr_status && reg_wdata[wake_ctrl_pkg::ST_WAKE_PEND_BIT];

    // ----------------------------------------------------------------
    // Power state and write gate
    // ----------------------------------------------------------------
    always_comb
    begin
        next_power_state = power_state;
        next_read_seen = read_seen;
        case (power_state)
            wake_ctrl_pkg::PWR_RUN:
            begin
                if (wr_power && reg_wdata[wake_ctrl_pkg::PWR_SLEEP_BIT])
                begin
                    next_power_state = wake_ctrl_pkg::PWR_SLEEP;
                end
            end
            wake_ctrl_pkg::PWR_SLEEP:
            begin
                // Data and address are not looked at; the event input has no say
                if (wake_write)
                begin
                    next_power_state = wake_ctrl_pkg::PWR_RUN;
                end
            end
            default:
            begin
                next_power_state = wake_ctrl_pkg::PWR_RUN;
            end
        endcase
        // Leaving sleep closes the write gate again until a read
        if (wake_write)
        begin
            next_read_seen = 1'b0;
        end
        else if (reg_read)
        begin
            next_read_seen = 1'b1;
        end
        if (!core_rst_n)
        begin
            next_power_state = wake_ctrl_pkg::PWR_RUN;
            next_read_seen = 1'b0;
        end
    end

    // Reference clock is the only clock of the block
    always_ff @(posedge clk)
    begin
        power_state <= next_power_state;
        read_seen <= next_read_seen;
    end

    // ----------------------------------------------------------------
    // Wake configuration and pending event
    // ----------------------------------------------------------------
    always_comb
    begin
        next_wake_config = wake_config;
        next_wake_pending = wake_pending;
        if (wr_config)
        begin
            next_wake_config.wake_enable = reg_wdata[wake_ctrl_pkg::CFG_WAKE_EN_BIT];
            next_wake_config.polarity_high = reg_wdata[wake_ctrl_pkg::CFG_POL_HIGH_BIT];
            next_wake_config.push_pull = reg_wdata[wake_ctrl_pkg::CFG_PUSH_PULL_BIT];
        end
        // Set beats a simultaneous clear so no event is lost
        if (wake_event)
        begin
            next_wake_pending = 1'b1;
        end
        else if (clear_pending)
        begin
            next_wake_pending = 1'b0;
        end
        if (!core_rst_n)
        begin
            next_wake_config.wake_enable = wake_ctrl_pkg::RST_WAKE_EN;
            next_wake_config.polarity_high = wake_ctrl_pkg::RST_POL_HIGH;
            next_wake_config.push_pull = wake_ctrl_pkg::RST_PUSH_PULL;
            next_wake_pending = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        wake_config <= next_wake_config;
        wake_pending <= next_wake_pending;
    end

    // ----------------------------------------------------------------
    // Wake indicator pin
    // ----------------------------------------------------------------
    assign indicator_active = wake_config.wake_enable && next_wake_pending;
    assign indicator_level = indicator_active == wake_config.polarity_high;

    always_comb
    begin
        if (wake_config.push_pull)
        begin
            next_wake_indicator_out = indicator_level;
            next_wake_indicator_oe = 1'b1;
        end
        else
        begin
            // Open drain only pulls low; a high level comes from the pull-up
            next_wake_indicator_out = 1'b0;
            next_wake_indicator_oe = !indicator_level;
        end
        if (!core_rst_n)
        begin
            next_wake_indicator_out = 1'b0;
            next_wake_indicator_oe = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        wake_indicator_out <= next_wake_indicator_out;
        wake_indicator_oe <= next_wake_indicator_oe;
    end

    // ----------------------------------------------------------------
    // Speed strap capture
    // ----------------------------------------------------------------
    always_comb
    begin
        next_strap_taken = strap_taken;
        next_strap_value = strap_value;
        next_eth_defaults = eth_defaults;
        // First edge after core reset release takes the strap, once only
        if (!strap_taken)
        begin
            next_strap_taken = 1'b1;
            next_strap_value = speed_strap;
            next_eth_defaults = strap_defaults(speed_strap);
        end
        if (!core_rst_n)
        begin
            next_strap_taken = 1'b0;
            next_strap_value = 1'b0;
            next_eth_defaults = strap_defaults(1'b0);
        end
    end

    always_ff @(posedge clk)
    begin
        strap_taken <= next_strap_taken;
        strap_value <= next_strap_value;
        eth_defaults <= next_eth_defaults;
    end

    // ----------------------------------------------------------------
    // Status word
    // ----------------------------------------------------------------
    always_comb
    begin
        status_word = wake_ctrl_pkg::RST_RDATA;
        status_word[wake_ctrl_pkg::ST_ASLEEP_BIT] = is_asleep(power_state);
        status_word[wake_ctrl_pkg::ST_WRITES_OK_BIT] = read_seen;
        status_word[wake_ctrl_pkg::ST_STRAP_BIT] = strap_value;
        status_word[wake_ctrl_pkg::ST_WAKE_PEND_BIT] = wake_pending;
        status_word[wake_ctrl_pkg::ST_SPEED100_BIT] = eth_defaults.speed_100;
        status_word[wake_ctrl_pkg::ST_FULL_DUPLEX_BIT] = eth_defaults.full_duplex;
        status_word[wake_ctrl_pkg::ST_AUTONEG_BIT] = eth_defaults.autoneg;
    end

    // ----------------------------------------------------------------
    // Power state outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        next_asleep = is_asleep(next_power_state);
        next_writes_enabled = next_read_seen;
        if (!core_rst_n)
        begin
            next_asleep = 1'b0;
            next_writes_enabled = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        asleep <= next_asleep;
        writes_enabled <= next_writes_enabled;
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_comb
    begin
        next_reg_rdata = wake_ctrl_pkg::RST_RDATA;
        if (reg_read)
        begin
            if (addr_is(reg_addr, wake_ctrl_pkg::BYTE_ORDER_TEST_OFS))
            begin
                next_reg_rdata = wake_ctrl_pkg::BYTE_ORDER_TEST_VALUE;
            end
            else if (addr_is(reg_addr, wake_ctrl_pkg::WAKE_CONFIG_OFS))
            begin
                next_reg_rdata[wake_ctrl_pkg::CFG_WAKE_EN_BIT] = wake_config.wake_enable;
                next_reg_rdata[wake_ctrl_pkg::CFG_POL_HIGH_BIT] = wake_config.polarity_high;
                next_reg_rdata[wake_ctrl_pkg::CFG_PUSH_PULL_BIT] = wake_config.push_pull;
            end
            else if (addr_is(reg_addr, wake_ctrl_pkg::POWER_CONTROL_OFS))
            begin
                next_reg_rdata[wake_ctrl_pkg::PWR_SLEEP_BIT] =
                    (power_state == wake_ctrl_pkg::PWR_SLEEP);
            end
            else if (addr_is(reg_addr, wake_ctrl_pkg::STATUS_OFS))
            begin
                next_reg_rdata = status_word;
            end
        end
        if (!core_rst_n)
        begin
            next_reg_rdata = wake_ctrl_pkg::RST_RDATA;
        end
    end

    always_ff @(posedge clk)
    begin
        reg_rdata <= next_reg_rdata;
    end

endmodule // reset_wake_strap_control

// ==== bench/host_model.sv ====
// Host processor model driving the register port and the strobe pins
`timescale 1ns/1ps

module host_model
(
    // Clock and read data
    input wire logic clk,
    input wire logic [wake_ctrl_pkg::DATA_W-1:0] reg_rdata,
    // Register port and strobe pins
    output logic [wake_ctrl_pkg::ADDR_W-1:0] reg_addr,
    output logic [wake_ctrl_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    output logic chip_select_low,
    output logic write_strobe_low
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        chip_select_low = 1'b1;
        write_strobe_low = 1'b1;
    end

    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    // Every write pulls the strobe pins too, as a real host does
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        chip_select_low <= 1'b0;
        write_strobe_low <= 1'b0;
        @(posedge clk);
        reg_write <= 1'b0;
        chip_select_low <= 1'b1;
        write_strobe_low <= 1'b1;
        // Released bus must not keep showing the last value
        reg_wdata <= ~d;
        reg_addr <= ~a;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask

    task automatic wake(input logic [31:0] d);
        wr(wake_ctrl_pkg::BYTE_ORDER_TEST_OFS, d);
    endtask
endmodule // host_model

// ==== bench/reset_wake_strap_control_properties.sv ====
// Concurrent checks on the ports of the reset, wake and strap block
`timescale 1ns/1ps

module reset_wake_strap_checker
(
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hard_reset_pin,
    // Host side
    input wire logic chip_select_low,
    input wire logic write_strobe_low,
    input wire logic [wake_ctrl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wake_ctrl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [wake_ctrl_pkg::DATA_W-1:0] reg_rdata,
    // Events, strap and outputs
    input wire logic wake_event,
    input wire logic speed_strap,
    input wire logic wake_indicator_out,
    input wire logic wake_indicator_oe,
    input wire logic asleep,
    input wire logic writes_enabled,
    input wire wake_ctrl_pkg::eth_defaults_t eth_defaults
);
    logic run;
    logic pin_wake;
    logic sleep_req;
    logic [2:0] run_cnt;
    logic [2:0] next_run_cnt;

    assign run = rst_n && hard_reset_pin;
    assign pin_wake = !chip_select_low && !write_strobe_low;
    assign sleep_req = writes_enabled && reg_write && reg_wdata[0]
        && (reg_addr == wake_ctrl_pkg::POWER_CONTROL_OFS);

    // ----------------------------------------------------------------
    // Edges since both resets went high, saturating
    // ----------------------------------------------------------------
    always_comb
    begin
        next_run_cnt = run_cnt;
        if (!run)
            next_run_cnt = 3'h0;
        else if (run_cnt != 3'h7)
            next_run_cnt = run_cnt + 3'h1;
    end

    always_ff @(posedge clk)
    begin
        run_cnt <= next_run_cnt;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!run);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Reset chain lags, so three low samples before the outputs are due
    reset_clears_a: assert property (disable iff (1'b0) (!run)[*3] |->
        (!asleep && !writes_enabled && eth_defaults == 3'h0 && reg_rdata == 32'h00000000
        && !wake_indicator_oe && !wake_indicator_out))
        else $error("outputs not cleared under reset");
    read_enables_a: assert property (reg_read && !asleep |=> writes_enabled)
        else $error("read did not enable writes");
    sleep_by_write_a: assert property ($rose(asleep) |-> $past(sleep_req))
        else $error("sleep entered without an accepted write");
    wake_by_pins_a: assert property ($fell(asleep) |-> $past(pin_wake))
        else $error("sleep left without a host write cycle");
    pins_wake_a: assert property (asleep && pin_wake |=> !asleep && !writes_enabled)
        else $error("host write cycle did not wake");
    event_no_wake_a: assert property (asleep && wake_event && !pin_wake |=> asleep)
        else $error("wake event ended sleep");
    strap_hold_a: assert property (run_cnt == 3'h7 |-> $stable(eth_defaults))
        else $error("defaults changed after latch");
    strap_shape_a: assert property (!eth_defaults.full_duplex
        && eth_defaults.speed_100 == eth_defaults.autoneg)
        else $error("defaults not a legal strap setting");
    strap_early_a: assert property (run_cnt < 3'h2 |-> eth_defaults == 3'h0)
        else $error("defaults left reset too early");
endmodule // reset_wake_strap_checker

bind reset_wake_strap_control reset_wake_strap_checker u_chk
(
    .clk, .rst_n, .hard_reset_pin, .chip_select_low, .write_strobe_low, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .wake_event, .speed_strap,
    .wake_indicator_out, .wake_indicator_oe, .asleep, .writes_enabled, .eth_defaults
);

// ==== bench/tb.sv ====
// Self-checking bench for the reset, wake and strap block
`timescale 1ns/1ps

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
    logic clk, rst_n, hard_reset_pin, wake_event, speed_strap;
    logic reg_write, reg_read, chip_select_low, write_strobe_low;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic wake_indicator_out, wake_indicator_oe, asleep, writes_enabled;
    logic act;
    wake_ctrl_pkg::eth_defaults_t eth_defaults;
    int fail_count;
    int num_checks;

    reset_wake_strap_control u_dut (.clk, .rst_n, .hard_reset_pin, .chip_select_low,
        .write_strobe_low, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .wake_event, .speed_strap, .wake_indicator_out, .wake_indicator_oe, .asleep,
        .writes_enabled, .eth_defaults);
    host_model u_host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .chip_select_low, .write_strobe_low);

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("checks=%0d errors=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        u_host.rd(a, d);
        `CHK(d, e)
    endtask

    task automatic pulse();
        @(posedge clk);
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
    endtask

    // Open drain never drives high; it only lets go
    task automatic ind_chk(input logic [2:0] c, input logic pend);
        repeat (3) @(posedge clk);
        act = c[0] & pend;
        if (c[2])
            `CHK({wake_indicator_oe, wake_indicator_out}, {1'b1, act == c[1]})
        else
            `CHK({wake_indicator_oe, wake_indicator_out}, {act != c[1], 1'b0})
    endtask

    initial
    begin
        #2000000;
        fail_count++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        hard_reset_pin = 1'b1;
        wake_event = 1'b0;
        speed_strap = 1'b1;
        fail_count = 0;
        num_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(writes_enabled, 1'b0)
        `CHK(eth_defaults, 3'h5)
        `CHK({wake_indicator_oe, wake_indicator_out}, 2'h0)
        u_host.wr(wake_ctrl_pkg::WAKE_CONFIG_OFS, 32'h00000007);
        rdchk(wake_ctrl_pkg::WAKE_CONFIG_OFS, 32'h00000000);
        u_host.wr(wake_ctrl_pkg::WAKE_CONFIG_OFS, 32'h00000007);
        rdchk(wake_ctrl_pkg::WAKE_CONFIG_OFS, 32'h00000007);
        u_host.wr(wake_ctrl_pkg::BYTE_ORDER_TEST_OFS, 32'h00000000);
        rdchk(wake_ctrl_pkg::BYTE_ORDER_TEST_OFS, wake_ctrl_pkg::BYTE_ORDER_TEST_VALUE);
        rdchk(8'h10, 32'h00000000);
        for (int c = 0; c < 8; c++)
        begin
            u_host.wr(wake_ctrl_pkg::WAKE_CONFIG_OFS, 32'(c));
            u_host.wr(wake_ctrl_pkg::STATUS_OFS, 32'h00000008);
            ind_chk(3'(c), 1'b0);
            pulse();
            ind_chk(3'(c), 1'b1);
        end
        for (int k = 0; k < 2; k++)
        begin
            u_host.wr(wake_ctrl_pkg::POWER_CONTROL_OFS, 32'h00000001);
            @(posedge clk);
            `CHK(asleep, 1'b1)
            // A read while asleep must not wake, nor open writes after the wake
            rdchk(wake_ctrl_pkg::POWER_CONTROL_OFS, 32'h00000001);
            pulse();
            repeat (2) @(posedge clk);
            `CHK(asleep, 1'b1)
            u_host.wake(k ? 32'hFFFFFFFF : 32'h00000000);
            @(posedge clk);
            `CHK(asleep, 1'b0)
            `CHK(writes_enabled, 1'b0)
            u_host.wr(wake_ctrl_pkg::WAKE_CONFIG_OFS, 32'h00000002);
            rdchk(wake_ctrl_pkg::WAKE_CONFIG_OFS, 32'h00000007);
        end
        // Running, writes open, event pending, strap 1 gives 100M half with AN
        rdchk(wake_ctrl_pkg::STATUS_OFS, 32'h0000005E);
        speed_strap <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(eth_defaults, 3'h5)
        hard_reset_pin <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK(writes_enabled, 1'b0)
        `CHK({wake_indicator_oe, wake_indicator_out}, 2'h0)
        hard_reset_pin <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(eth_defaults, 3'h0)
        // Strap 0 matches the reset value, so show it is held, not followed
        speed_strap <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(eth_defaults, 3'h0)
        rdchk(wake_ctrl_pkg::WAKE_CONFIG_OFS, 32'h00000000);
        conclude();
    end
endmodule // tb
